//--- src/dds_defs.vh
`ifndef DDS_DEFS_VH
`define DDS_DEFS_VH

// =====================================================
// register offsets
`define DDS_ADR_CTRL      8'h00
`define DDS_ADR_FREQ0     8'h04
`define DDS_ADR_FREQ1     8'h08
`define DDS_ADR_PHASE0    8'h0c
`define DDS_ADR_PHASE1    8'h10
`define DDS_ADR_STATUS    8'h14

// =====================================================
// control field positions
`define DDS_CTRL_MODE     1
`define DDS_CTRL_HALVE    3
`define DDS_CTRL_SQ       5
`define DDS_CTRL_DACPD    6
`define DDS_CTRL_CLKDIS   7
`define DDS_CTRL_PSEL     10
`define DDS_CTRL_FSEL     11
`define DDS_CTRL_MASK     16'h0cea

// =====================================================
// reset values
`define DDS_CTRL_RST      16'h0000
`define DDS_FREQ_RST      28'h0000000
`define DDS_PHASE_RST     12'h000
`define DDS_OUT_MID       10'h200
`define DDS_RAMP_RST      10'h000
`define DDS_SQ_HI         10'h3ff
`define DDS_SQ_LO         10'h000

// =====================================================
// status field positions
`define DDS_ST_CODE_LSB   12
`define DDS_ST_RUN        24
`define DDS_ST_DACPD      25

// =====================================================
// widths and timing
`define DDS_FREQ_W        28
`define DDS_PHASE_W       12
`define DDS_DAC_W         10
`define DDS_PIPE_LAT      3

`endif

//--- src/dds_output_select_and_sleep.v
`timescale 1ns/1ns
`default_nettype none
`include "dds_defs.vh"

module dds_output_select_and_sleep (
	input  wire                   clk_i,
	input  wire                   rst_i,
	input  wire                   wb_cyc_i,
	input  wire                   wb_stb_i,
	input  wire                   wb_we_i,
	input  wire [7:0]             wb_adr_i,
	input  wire [3:0]             wb_sel_i,
	input  wire [31:0]            wb_dat_i,
	output reg  [31:0]            wb_dat_o,
	output reg                    wb_ack_o,
	output reg  [`DDS_DAC_W-1:0]  analog_output_pin_o,
	output reg                    dac_powerdown_o,
	output reg                    clock_running_o
);

// =====================================================
// byte lane merge
function [31:0] dds_merge;
	input [31:0] old_v;
	input [31:0] new_v;
	input [3:0]  sel;
	integer      k;
	begin
		dds_merge = old_v;
		for (k = 0; k < 4; k = k + 1) begin
			if (sel[k]) begin
				dds_merge[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
	end
endfunction

// =====================================================
// declarations
reg  [15:0]              ctrl_r;
reg  [`DDS_FREQ_W-1:0]   freq0_r;
reg  [`DDS_FREQ_W-1:0]   freq1_r;
reg  [`DDS_PHASE_W-1:0]  phase0_r;
reg  [`DDS_PHASE_W-1:0]  phase1_r;
reg  [`DDS_FREQ_W-1:0]   acc_r;
reg  [`DDS_PHASE_W-1:0]  phase_r;
reg  [`DDS_DAC_W-1:0]    ramp_r;
reg  [31:0]              rd_nxt;
reg  [`DDS_DAC_W-1:0]    out_nxt;

wire                     req;
wire                     wr;
wire                     wr_ctrl;
wire                     wr_freq0;
wire                     wr_freq1;
wire                     wr_phase0;
wire                     wr_phase1;
wire [2:0]               src_sel;
wire                     run;
wire                     clk_dis;
wire                     mode;
wire                     sq_en;
wire                     halve;
wire [31:0]              m_ctrl;
wire [31:0]              m_freq0;
wire [31:0]              m_freq1;
wire [31:0]              m_phase0;
wire [31:0]              m_phase1;
wire [`DDS_FREQ_W-1:0]   selected_frequency_word;
wire [`DDS_PHASE_W-1:0]  selected_phase_word;
wire [`DDS_DAC_W-1:0]    sine_code;
wire                     sq_bit;

// =====================================================
// control decode
assign clk_dis = ctrl_r[`DDS_CTRL_CLKDIS];
assign run     = ~clk_dis;
assign mode    = ctrl_r[`DDS_CTRL_MODE];
assign sq_en   = ctrl_r[`DDS_CTRL_SQ];
assign halve   = ctrl_r[`DDS_CTRL_HALVE];

// =====================================================
// wishbone slave, one wait state
assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr  = req & wb_we_i;

assign m_ctrl   = dds_merge({16'h0000, ctrl_r}, wb_dat_i, wb_sel_i);
assign m_freq0  = dds_merge({4'h0, freq0_r}, wb_dat_i, wb_sel_i);
assign m_freq1  = dds_merge({4'h0, freq1_r}, wb_dat_i, wb_sel_i);
assign m_phase0 = dds_merge({20'h00000, phase0_r}, wb_dat_i, wb_sel_i);
assign m_phase1 = dds_merge({20'h00000, phase1_r}, wb_dat_i, wb_sel_i);

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
	end else begin
		wb_ack_o <= req;
	end
end

// =====================================================
// address match, one write strobe per writable register, none for status
function dds_hit;
	input [7:0] adr;
	input [7:0] offs;
	begin
		dds_hit = (adr == offs);
	end
endfunction

assign wr_ctrl   = wr & dds_hit(wb_adr_i, `DDS_ADR_CTRL);
assign wr_freq0  = wr & dds_hit(wb_adr_i, `DDS_ADR_FREQ0);
assign wr_freq1  = wr & dds_hit(wb_adr_i, `DDS_ADR_FREQ1);
assign wr_phase0 = wr & dds_hit(wb_adr_i, `DDS_ADR_PHASE0);
assign wr_phase1 = wr & dds_hit(wb_adr_i, `DDS_ADR_PHASE1);

// =====================================================
// registers, written whether or not the clock is disabled
always @(posedge clk_i) begin
	if (rst_i) begin
		ctrl_r <= `DDS_CTRL_RST;
	end else if (wr_ctrl) begin
		ctrl_r <= m_ctrl[15:0] & `DDS_CTRL_MASK;
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		freq0_r <= `DDS_FREQ_RST;
	end else if (wr_freq0) begin
		freq0_r <= m_freq0[`DDS_FREQ_W-1:0];
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		freq1_r <= `DDS_FREQ_RST;
	end else if (wr_freq1) begin
		freq1_r <= m_freq1[`DDS_FREQ_W-1:0];
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		phase0_r <= `DDS_PHASE_RST;
	end else if (wr_phase0) begin
		phase0_r <= m_phase0[`DDS_PHASE_W-1:0];
	end
end

always @(posedge clk_i) begin
	if (rst_i) begin
		phase1_r <= `DDS_PHASE_RST;
	end else if (wr_phase1) begin
		phase1_r <= m_phase1[`DDS_PHASE_W-1:0];
	end
end

// =====================================================
// read mux
always @* begin
	rd_nxt = 32'h00000000;
	case (wb_adr_i)
		`DDS_ADR_CTRL: begin
			rd_nxt = {16'h0000, ctrl_r};
		end
		`DDS_ADR_FREQ0: begin
			rd_nxt = {4'h0, freq0_r};
		end
		`DDS_ADR_FREQ1: begin
			rd_nxt = {4'h0, freq1_r};
		end
		`DDS_ADR_PHASE0: begin
			rd_nxt = {20'h00000, phase0_r};
		end
		`DDS_ADR_PHASE1: begin
			rd_nxt = {20'h00000, phase1_r};
		end
		`DDS_ADR_STATUS: begin
			rd_nxt[`DDS_PHASE_W-1:0] = phase_r;
			rd_nxt[`DDS_ST_CODE_LSB +: `DDS_DAC_W] = analog_output_pin_o;
			rd_nxt[`DDS_ST_RUN] = clock_running_o;
			rd_nxt[`DDS_ST_DACPD] = dac_powerdown_o;
		end
		default: begin
			rd_nxt = 32'h00000000;
		end
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_dat_o <= 32'h00000000;
	end else if (req && !wb_we_i) begin
		wb_dat_o <= rd_nxt;
	end
end

// =====================================================
// register selection, follows select bits every cycle
assign selected_frequency_word = ctrl_r[`DDS_CTRL_FSEL] ? freq1_r : freq0_r;
assign selected_phase_word = ctrl_r[`DDS_CTRL_PSEL] ? phase1_r : phase0_r;

// =====================================================
// phase accumulator, stage 0
always @(posedge clk_i) begin
	if (rst_i) begin
		acc_r <= `DDS_FREQ_RST;
	end else if (run) begin
		acc_r <= acc_r + selected_frequency_word;
	end
end

// =====================================================
// phase offset, stage 1
always @(posedge clk_i) begin
	if (rst_i) begin
		phase_r <= `DDS_PHASE_RST;
	end else if (run) begin
		phase_r <= acc_r[`DDS_FREQ_W-1 -: `DDS_PHASE_W] + selected_phase_word;
	end
end

// =====================================================
// waveform sources, stage 2
always @(posedge clk_i) begin
	if (rst_i) begin
		ramp_r <= `DDS_RAMP_RST;
	end else if (run) begin
		ramp_r <= phase_r[11] ? ~phase_r[10:1] : phase_r[10:1];
	end
end

dds_sine_rom u_rom (
	.clk_i   (clk_i),
	.rst_i   (rst_i),
	.en_i    (run),
	.phase_i (phase_r),
	.code_o  (sine_code)
);

dds_square_div u_sq (
	.clk_i   (clk_i),
	.rst_i   (rst_i),
	.en_i    (run),
	.msb_i   (phase_r[11]),
	.halve_i (halve),
	.sq_o    (sq_bit)
);

// =====================================================
// source select, square wins the reserved combination
localparam [2:0] SRC_SINE = 3'b001;
localparam [2:0] SRC_RAMP = 3'b010;
localparam [2:0] SRC_SQ   = 3'b100;

assign src_sel = sq_en ? SRC_SQ : (mode ? SRC_RAMP : SRC_SINE);

// =====================================================
// output select, stage 3
always @* begin
	out_nxt = sine_code;
	case (src_sel)
		SRC_SINE: begin
			out_nxt = sine_code;
		end
		SRC_RAMP: begin
			out_nxt = ramp_r;
		end
		SRC_SQ: begin
			out_nxt = sq_bit ? `DDS_SQ_HI : `DDS_SQ_LO;
		end
		default: begin
			out_nxt = sine_code;
		end
	endcase
end

always @(posedge clk_i) begin
	if (rst_i) begin
		analog_output_pin_o <= `DDS_OUT_MID;
	end else if (run) begin
		analog_output_pin_o <= out_nxt;
	end
end

// =====================================================
// power down outputs
always @(posedge clk_i) begin
	if (rst_i) begin
		dac_powerdown_o <= 1'b0;
		clock_running_o <= 1'b1;
	end else begin
		dac_powerdown_o <= ctrl_r[`DDS_CTRL_DACPD];
		clock_running_o <= run;
	end
end

endmodule // dds_output_select_and_sleep
`default_nettype wire

//--- src/dds_sine_rom.v
`timescale 1ns/1ns
`default_nettype none
`include "dds_defs.vh"

module dds_sine_rom (
	input  wire                     clk_i,
	input  wire                     rst_i,
	input  wire                     en_i,
	input  wire [`DDS_PHASE_W-1:0]  phase_i,
	output reg  [`DDS_DAC_W-1:0]    code_o
);

// =====================================================
// quarter wave table, 32 entries of 9 bits
localparam [32*9-1:0] TABLE = {
	9'h1ff, 9'h1fe, 9'h1fb, 9'h1f7, 9'h1f3, 9'h1ec, 9'h1e5, 9'h1dd,
	9'h1d3, 9'h1c8, 9'h1bd, 9'h1b0, 9'h1a2, 9'h193, 9'h183, 9'h172,
	9'h160, 9'h14e, 9'h13a, 9'h126, 9'h111, 9'h0fc, 9'h0e6, 9'h0cf,
	9'h0b8, 9'h0a0, 9'h088, 9'h070, 9'h057, 9'h03f, 9'h026, 9'h00d
};

wire [4:0] idx;
wire [8:0] amp;

assign idx = phase_i[10] ? ~phase_i[9:5] : phase_i[9:5];
assign amp = TABLE[idx*9 +: 9];

// =====================================================
// registered read, held while stalled
always @(posedge clk_i) begin
	if (rst_i) begin
		code_o <= `DDS_OUT_MID;
	end else if (en_i) begin
		code_o <= phase_i[11] ? (10'h1ff - {1'b0, amp}) : (10'h200 + {1'b0, amp});
	end
end

endmodule // dds_sine_rom
`default_nettype wire

//--- src/dds_square_div.v
`timescale 1ns/1ns
`default_nettype none

module dds_square_div (
	input  wire clk_i,
	input  wire rst_i,
	input  wire en_i,
	input  wire msb_i,
	input  wire halve_i,
	output reg  sq_o
);

reg prev_r;
reg div_r;

// =====================================================
// msb pass-through or divide by two
always @(posedge clk_i) begin
	if (rst_i) begin
		prev_r <= 1'b0;
		div_r  <= 1'b0;
		sq_o   <= 1'b0;
	end else if (en_i) begin
		prev_r <= msb_i;
		if (msb_i && !prev_r) begin
			div_r <= ~div_r;
		end
		sq_o <= halve_i ? msb_i : div_r;
	end
end

endmodule // dds_square_div
`default_nettype wire

//--- test/dds_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// host side bus master
module dds_host_model (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output var  logic        cyc_o,
	output var  logic        stb_o,
	output var  logic        we_o,
	output var  logic [7:0]  adr_o,
	output var  logic [3:0]  sel_o,
	output var  logic [31:0] dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'hf;
		dat_o = 32'h0;
	end
	// one classic cycle, held until ack
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		dat_o <= d;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
		@(posedge clk_i);
	endtask
endmodule // dds_host_model
`default_nettype wire

//--- test/dds_osc_properties.sv
`timescale 1ns/1ns
`default_nettype none
`include "dds_defs.vh"
module dds_osc_chk (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic [`DDS_DAC_W-1:0] analog_output_pin_o,
	input wire logic                  dac_powerdown_o,
	input wire logic                  clock_running_o
);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_ctrl = req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// bus handshake
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_on_req: assert property (req |=> wb_ack_o)
		else $error("request not acked");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	// ==========
	// sleep control
	a_dac_pd_follow: assert property (wr_ctrl |-> ##2 dac_powerdown_o == $past(wb_dat_i[6], 2))
		else $error("dac powerdown wrong");
	a_clk_run_follow: assert property (wr_ctrl |-> ##2 clock_running_o == !$past(wb_dat_i[7], 2))
		else $error("clock running wrong");
	a_frozen_out: assert property (!clock_running_o && !$past(clock_running_o) |-> $stable(analog_output_pin_o))
		else $error("output moved while frozen");
	a_reset_mid: assert property ($fell(rst_i) |-> analog_output_pin_o == 10'h200 && clock_running_o && !dac_powerdown_o)
		else $error("bad state after reset");
endmodule // dds_osc_chk
bind dds_output_select_and_sleep dds_osc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_output_pin_o(analog_output_pin_o),
	.dac_powerdown_o(dac_powerdown_o), .clock_running_o(clock_running_o));
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc, stb, we, ack, pd, run;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dw, dr, a, b;
	logic [9:0]  pin;
	int          num_errors = 0;
	int          num_checks = 0;
	always #10 clk_i = ~clk_i;
	dds_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(dw));
	dds_output_select_and_sleep u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
		.analog_output_pin_o(pin), .dac_powerdown_o(pd), .clock_running_o(run));
	// ==========
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		u_host.xfer(1'b1, ad, d, b);
	endtask
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		u_host.xfer(1'b0, ad, 32'h0, b);
		chk(b, e);
	endtask
	task automatic w6;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic edges(input logic [31:0] e);
		logic [9:0] p;
		logic [31:0] n;
		n = 32'h0;
		p = pin;
		repeat (64) begin
			@(posedge clk_i);
			if (pin !== p) n++;
			p = pin;
		end
		chk(n, e);
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rc(8'h00, 32'h0);
		rc(8'h14, 32'h0120d000);
		$display("test reset done");
		wr(8'h0c, 32'h100);
		wr(8'h00, 32'h2);
		w6;
		rc(8'h14, 32'h01080100);
		wr(8'h10, 32'hc00);
		wr(8'h00, 32'h402);
		w6;
		rc(8'h14, 32'h011ffc00);
		$display("test ramp done");
		wr(8'h00, 32'h482);
		w6;
		rc(8'h14, 32'h001ffc00);
		chk({30'h0, pd, run}, 32'h0);
		wr(8'h08, 32'h10000);
		wr(8'h00, 32'hc82);
		rc(8'h08, 32'h10000);
		rc(8'h00, 32'hc82);
		rc(8'h14, 32'h001ffc00);
		$display("test sleep done");
		wr(8'h00, 32'hc02);
		w6;
		u_host.xfer(1'b0, 8'h14, 32'h0, a);
		u_host.xfer(1'b0, 8'h14, 32'h0, b);
		chk((b - a) & 32'hfff, 32'h3);
		chk(b & 32'h03000000, 32'h01000000);
		$display("test resume done");
		wr(8'h08, 32'h1000000);
		wr(8'h00, 32'hc68);
		w6;
		u_host.xfer(1'b0, 8'h14, 32'h0, a);
		chk({30'h0, a[25], a[21:12] == 10'h3ff || a[21:12] == 10'h0}, 32'h3);
		chk({30'h0, pd, run}, 32'h3);
		edges(32'h8);
		wr(8'h00, 32'hc60);
		w6;
		edges(32'h4);
		$display("test square done");
		wr(8'h00, 32'hc0);
		chk({30'h0, pd, run}, 32'h2);
		wr(8'h00, 32'h0);
		chk({30'h0, pd, run}, 32'h1);
		rc(8'h20, 32'h0);
		wr(8'h20, 32'hffffffff);
		wr(8'h00, 32'hff9d);
		rc(8'h00, 32'h0c88);
		$display("test map done");
		close_out;
	end
	initial begin
		repeat (3000) @(posedge clk_i);
		num_errors++;
		close_out;
	end
endmodule // tb
`default_nettype wire
